// *** uart_pins_pkg.sv ***
// package: constants and carrier types for the two-port uart pin block
package uart_pins_pkg;
  // ----------------------------------------
  // framing and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BAUD = 115200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] BIT_CNT_RST = 8'h00;
  localparam logic [3:0] IDX_RST = 4'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic MARK_LEVEL = 1'b1;
  localparam logic RTS_INACTIVE = 1'b1;
  localparam logic CTS_RST = 1'b1;
  localparam int unsigned NUM_PORTS = 2;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_t;

  typedef struct packed {
    logic parityEn;
    logic parityOdd;
    logic twoStop;
  } frame_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } ser_state_t;
endpackage : uart_pins_pkg

// *** uart_pin_modem_control.sv ***
// module: serial pins of two asynchronous ports and modem control of port 0
// ----------------------------------------
// Functional notes
// - after reset each transmit output sits at marking high until a character starts.
// - the clear-to-send level is sampled and offered as a readable modem status.
// - request-to-send is driven low to tell the modem the port is ready.
// - reset drives request-to-send high.
// - in loopback mode request-to-send stays high whatever the internal request.
// - outside loopback mode each port takes its incoming bits on its own receive input; in loopback it takes its own transmit line.
// ----------------------------------------
module uart_pin_modem_control (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // user side
  input wire uart_pins_pkg::frame_cfg_t frameCfg,
  input wire logic loopMode,
  input wire logic requestToSend,
  input wire uart_pins_pkg::char_t [1:0] txChar,
  output logic [1:0] txBusy,
  output uart_pins_pkg::char_t [1:0] rxChar,
  output logic [1:0] rxFrameErr,
  output logic clearToSendStatus,
  // serial pins
  input wire logic port0_serial_in,
  input wire logic port1_serial_in,
  input wire logic port0_clear_to_send_low,
  output logic port0_serial_out,
  output logic port1_serial_out,
  output logic port0_request_to_send_low
);
  import uart_pins_pkg::*;

  logic [1:0] serIn;
  logic [1:0] serOut;

  // ----------------------------------------
  // receive inputs and loopback
  // ----------------------------------------
  // loopback feeds each port its own transmit line
  assign serIn[0] = loopMode ? serOut[0] : port0_serial_in;
  assign serIn[1] = loopMode ? serOut[1] : port1_serial_in;

  // ----------------------------------------
  // modem control
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      port0_request_to_send_low <= RTS_INACTIVE;
    end else if (loopMode) begin
      port0_request_to_send_low <= RTS_INACTIVE;
    end else begin
      port0_request_to_send_low <= ~requestToSend;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      clearToSendStatus <= CTS_RST;
    end else begin
      clearToSendStatus <= port0_clear_to_send_low;
    end
  end

  // ----------------------------------------
  // per-port transmitter and receiver
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      ser_state_t txSt_r;
      logic [7:0] txCnt_r;
      logic [3:0] txIdx_r;
      logic [7:0] txSh_r;
      logic txPar_r;
      logic txOut_r;
      ser_state_t rxSt_r;
      logic [7:0] rxCnt_r;
      logic [3:0] rxIdx_r;
      logic [7:0] rxSh_r;
      logic rxPar_r;
      logic txTick;
      logic rxTick;
      logic rxMid;

      assign txTick = (txCnt_r == 8'(BIT_CYCLES - 1));
      assign rxTick = (rxCnt_r == 8'(BIT_CYCLES - 1));
      assign rxMid = (rxCnt_r == 8'(BIT_CYCLES / 2));
      assign serOut[p] = txOut_r;

      always_ff @(posedge clk) begin
        if (!nrst) begin
          txSt_r <= ST_IDLE;
          txCnt_r <= BIT_CNT_RST;
          txIdx_r <= IDX_RST;
          txSh_r <= SHIFT_RST;
          txPar_r <= 1'b0;
          txOut_r <= MARK_LEVEL;
        end else begin
          txCnt_r <= (txSt_r == ST_IDLE || txTick) ? BIT_CNT_RST : txCnt_r + 8'h01;
          unique case (txSt_r)
            ST_IDLE: begin
              txOut_r <= MARK_LEVEL;
              if (txChar[p].valid) begin
                txSh_r <= txChar[p].data;
                txPar_r <= frameCfg.parityOdd;
                txIdx_r <= IDX_RST;
                txOut_r <= 1'b0;
                txSt_r <= ST_START;
              end
            end
            ST_START: begin
              if (txTick) begin
                txOut_r <= txSh_r[0];
                txPar_r <= txPar_r ^ txSh_r[0];
                txSh_r <= {1'b0, txSh_r[7:1]};
                txSt_r <= ST_DATA;
              end
            end
            ST_DATA: begin
              if (txTick) begin
                txIdx_r <= txIdx_r + 4'h1;
                if (txIdx_r == 4'(DATA_BITS - 1)) begin
                  txOut_r <= frameCfg.parityEn ? txPar_r : MARK_LEVEL;
                  txSt_r <= frameCfg.parityEn ? ST_PAR : ST_STOP;
                  txIdx_r <= IDX_RST;
                end else begin
                  txOut_r <= txSh_r[0];
                  txPar_r <= txPar_r ^ txSh_r[0];
                  txSh_r <= {1'b0, txSh_r[7:1]};
                end
              end
            end
            ST_PAR: begin
              if (txTick) begin
                txOut_r <= MARK_LEVEL;
                txSt_r <= ST_STOP;
              end
            end
            ST_STOP: begin
              txOut_r <= MARK_LEVEL;
              if (txTick) begin
                txIdx_r <= txIdx_r + 4'h1;
                if (!frameCfg.twoStop || txIdx_r != IDX_RST) begin
                  txSt_r <= ST_IDLE;
                end
              end
            end
            default: txSt_r <= ST_IDLE;
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (!nrst) begin
          txBusy[p] <= 1'b0;
        end else begin
          txBusy[p] <= (txSt_r != ST_IDLE) || txChar[p].valid;
        end
      end

      always_ff @(posedge clk) begin
        if (!nrst) begin
          rxSt_r <= ST_IDLE;
          rxCnt_r <= BIT_CNT_RST;
          rxIdx_r <= IDX_RST;
          rxSh_r <= SHIFT_RST;
          rxPar_r <= 1'b0;
          rxChar[p] <= '0;
          rxFrameErr[p] <= 1'b0;
        end else begin
          rxChar[p].valid <= 1'b0;
          rxFrameErr[p] <= 1'b0;
          rxCnt_r <= (rxSt_r == ST_IDLE || rxTick) ? BIT_CNT_RST : rxCnt_r + 8'h01;
          unique case (rxSt_r)
            ST_IDLE: begin
              if (!serIn[p]) begin
                rxSt_r <= ST_START;
                rxIdx_r <= IDX_RST;
                rxPar_r <= frameCfg.parityOdd;
              end
            end
            ST_START: begin
              if (rxMid && serIn[p]) begin
                rxSt_r <= ST_IDLE;
              end else if (rxTick) begin
                rxSt_r <= ST_DATA;
              end
            end
            ST_DATA: begin
              if (rxMid) begin
                rxSh_r <= {serIn[p], rxSh_r[7:1]};
                rxPar_r <= rxPar_r ^ serIn[p];
              end
              if (rxTick) begin
                rxIdx_r <= rxIdx_r + 4'h1;
                if (rxIdx_r == 4'(DATA_BITS - 1)) begin
                  rxSt_r <= frameCfg.parityEn ? ST_PAR : ST_STOP;
                end
              end
            end
            ST_PAR: begin
              if (rxMid) begin
                rxPar_r <= rxPar_r ^ serIn[p];
              end
              if (rxTick) begin
                rxSt_r <= ST_STOP;
              end
            end
            ST_STOP: begin
              if (rxMid) begin
                rxChar[p].valid <= 1'b1;
                rxChar[p].data <= rxSh_r;
                rxFrameErr[p] <= !serIn[p] || (frameCfg.parityEn && rxPar_r);
                rxSt_r <= ST_IDLE;
              end
            end
            default: rxSt_r <= ST_IDLE;
          endcase
        end
      end
    end
  endgenerate

  assign port0_serial_out = g_port[0].txOut_r;
  assign port1_serial_out = g_port[1].txOut_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_rst_mark;
    @(posedge clk) !nrst |=> port0_serial_out && port1_serial_out;
  endproperty
  a_rst_mark: assert property (p_rst_mark) else $error("tx not marking after reset");

  property p_idle_mark;
    @(posedge clk) disable iff (!nrst)
      (g_port[0].txSt_r == ST_IDLE && !txChar[0].valid) |=> port0_serial_out;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle tx not high");

  property p_cts;
    @(posedge clk) disable iff (!nrst) 1'b1 |=> clearToSendStatus == $past(port0_clear_to_send_low);
  endproperty
  a_cts: assert property (p_cts) else $error("cts status wrong");

  property p_rts_on;
    @(posedge clk) disable iff (!nrst)
      (requestToSend && !loopMode) |=> !port0_request_to_send_low;
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("rts not asserted");

  property p_rts_rst;
    @(posedge clk) !nrst |=> port0_request_to_send_low;
  endproperty
  a_rts_rst: assert property (p_rts_rst) else $error("rts not high after reset");

  property p_rts_loop;
    @(posedge clk) disable iff (!nrst) loopMode |=> port0_request_to_send_low;
  endproperty
  a_rts_loop: assert property (p_rts_loop) else $error("rts low in loop mode");

  property p_rx_start;
    @(posedge clk) disable iff (!nrst)
      (g_port[1].rxSt_r == ST_IDLE && !serIn[1]) |=> g_port[1].rxSt_r == ST_START;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("rx missed start bit");

  property p_start_bit;
    @(posedge clk) disable iff (!nrst)
      (g_port[0].txSt_r == ST_IDLE && txChar[0].valid) |=> !port0_serial_out [*2];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no low start bit");

  c_tx0: cover property (@(posedge clk) g_port[0].txSt_r == ST_STOP);
  c_rx0: cover property (@(posedge clk) rxChar[0].valid);
  c_loop: cover property (@(posedge clk) loopMode && rxChar[0].valid);
  c_err: cover property (@(posedge clk) rxFrameErr[0]);
endmodule : uart_pin_modem_control

// *** modem_model.sv ***
// modem model: far-side data set on the serial and clear-to-send lines
module modem_model
  import uart_pins_pkg::*;
(
  // clock
  input wire logic clk,
  // lines into the device
  output logic [1:0] serialIn,
  output logic ctsLow
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serialIn = 2'b11;
    ctsLow = 1'b1;
  end
  task automatic set_ready(input logic rdy);
    @(posedge clk);
    ctsLow <= ~rdy;
  endtask : set_ready
  // one frame on port p; stopLvl 0 breaks the stop bit
  task automatic send(input int p, input logic [7:0] d, input frame_cfg_t cfg,
                      input logic stopLvl);
    logic [10:0] bits;
    int n;
    bits = cfg.parityEn ? {stopLvl, ^d ^ cfg.parityOdd, d, 1'b0}
                        : {1'b1, stopLvl, d, 1'b0};
    n = cfg.parityEn ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      serialIn[p] <= bits[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
    @(posedge clk);
    serialIn[p] <= 1'b1;
  endtask : send
endmodule : modem_model

// *** tb_uart_pin_modem_control.sv ***
// testbench: two-port uart pins and modem control
module tb_uart_pin_modem_control;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_pins_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  frame_cfg_t frameCfg = 3'b000;
  logic loopMode = 1'b0;
  logic requestToSend = 1'b0;
  char_t [1:0] txChar = '0;
  logic [1:0] txBusy;
  char_t [1:0] rxChar;
  logic [1:0] rxFrameErr;
  logic clearToSendStatus;
  logic [1:0] serIn;
  logic ctsLow;
  logic [1:0] outs;
  logic rtsLow;
  int fail_count = 0;
  int cmp_count = 0;

  modem_model modem (.clk(clk), .serialIn(serIn), .ctsLow(ctsLow));
  uart_pin_modem_control dut (
    .clk(clk), .nrst(nrst), .frameCfg(frameCfg), .loopMode(loopMode),
    .requestToSend(requestToSend), .txChar(txChar), .txBusy(txBusy), .rxChar(rxChar),
    .rxFrameErr(rxFrameErr), .clearToSendStatus(clearToSendStatus),
    .port0_serial_in(serIn[0]), .port1_serial_in(serIn[1]),
    .port0_clear_to_send_low(ctsLow), .port0_serial_out(outs[0]),
    .port1_serial_out(outs[1]), .port0_request_to_send_low(rtsLow));

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // checking and verdict
  // ----------------------------------------
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rts();
    @(posedge clk);
    requestToSend <= 1'b1;
    repeat (3) @(negedge clk);
    check("rts ready", 9'(rtsLow), 9'h000);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    check("rts in reset", 9'(rtsLow), 9'h001);
    check("tx in reset", 9'(outs), 9'h003);
    @(posedge clk);
    nrst <= 1'b1;
    requestToSend <= 1'b0;
    repeat (3) @(negedge clk);
    check("rts idle", 9'(rtsLow), 9'h001);
  endtask : t_rts

  task automatic t_cts();
    modem.set_ready(1'b1);
    repeat (3) @(negedge clk);
    check("cts status low", 9'(clearToSendStatus), 9'h000);
    modem.set_ready(1'b0);
    repeat (3) @(negedge clk);
    check("cts status high", 9'(clearToSendStatus), 9'h001);
  endtask : t_cts

  task automatic t_tx(input int p, input logic [7:0] d, input frame_cfg_t cfg);
    logic [12:0] bits;
    int n;
    bits = {2'b11, cfg.parityEn ? {1'b1, ^d ^ cfg.parityOdd} : 2'b11, d, 1'b0};
    n = 10 + int'(cfg.parityEn) + int'(cfg.twoStop);
    @(posedge clk);
    frameCfg <= cfg;
    txChar[p] <= {1'b1, d};
    @(posedge clk);
    txChar[p] <= 9'h000;
    repeat (BIT_CYCLES / 2 + 1) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      check("tx bit", 9'(outs[p]), 9'(bits[i]));
      check("tx busy", 9'(txBusy[p]), 9'h001);
      check("other tx idle", 9'(outs[1 - p]), 9'h001);
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
    repeat (BIT_CYCLES) @(negedge clk);
    check("tx done", 9'({txBusy[p], outs[p]}), 9'h001);
  endtask : t_tx

  task automatic t_rx(input int p, input logic [7:0] d, input frame_cfg_t cfg,
                      input logic stopLvl);
    int k;
    k = 0;
    @(posedge clk);
    frameCfg <= cfg;
    fork
      modem.send(p, d, cfg, stopLvl);
      begin
        while (rxChar[p].valid !== 1'b1 && k < 3000) begin
          @(negedge clk);
          k++;
        end
        check("rx char", rxChar[p], {1'b1, d});
        check("rx error", 9'(rxFrameErr[p]), 9'(!stopLvl));
        check("other rx quiet", 9'(rxChar[1 - p].valid), 9'h000);
      end
    join
  endtask : t_rx

  task automatic t_loop();
    int k;
    k = 0;
    @(posedge clk);
    loopMode <= 1'b1;
    requestToSend <= 1'b1;
    frameCfg <= 3'b000;
    repeat (3) @(negedge clk);
    check("rts in loop", 9'(rtsLow), 9'h001);
    @(posedge clk);
    txChar[0] <= 9'h196;
    @(posedge clk);
    txChar[0] <= 9'h000;
    while (rxChar[0].valid !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    check("loop char", rxChar[0], 9'h196);
    check("rts still in loop", 9'(rtsLow), 9'h001);
  endtask : t_loop

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("tx after reset", 9'(outs), 9'h003);
    check("rts after reset", 9'(rtsLow), 9'h001);
    t_rts();
    t_cts();
    t_tx(0, 8'ha5, 3'b100);
    t_tx(1, 8'h3c, 3'b111);
    t_rx(0, 8'h5a, 3'b100, 1'b1);
    t_rx(1, 8'hc3, 3'b000, 1'b1);
    t_rx(1, 8'h81, 3'b110, 1'b0);
    t_loop();
    print_verdict();
  end
endmodule : tb_uart_pin_modem_control
